// ### acc_i2c_target.sv
// Device end: I2C target giving access to the accelerometer register file
`timescale 1ns/1ps
`include "acc_consts.svh"
module acc_i2c_target (
  input wire logic clk,
  input wire logic rst,
  acc_i2c_if.target bus,
  input wire logic three_wire_select,
  input wire logic target_busy,
  output acc_pkg::acc_reg_addr_t rd_addr,
  input wire acc_pkg::acc_byte_t rd_data,
  output logic wr_valid,
  input wire logic wr_ready,
  output acc_pkg::acc_reg_addr_t wr_addr,
  output acc_pkg::acc_byte_t wr_data,
  output logic bus_busy,
  output logic spi_select,
  output logic spi_three_wire
);
  import acc_pkg::*;

  localparam int FW = $bits(acc_reg_addr_t) + $bits(acc_byte_t);

  // ----------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic [1:0] cs_sync_q;
  logic [1:0] sdo_sync_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_s;
  logic sda_s;
  logic i2c_mode;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // Two flops on every pin before any logic looks at it
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      cs_sync_q <= 2'h3; // Strap idles high, so no false SPI spell after reset
      sdo_sync_q <= 2'h0;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], bus.scl};
      sda_sync_q <= {sda_sync_q[0], bus.sda};
      cs_sync_q <= {cs_sync_q[0], bus.cs};
      sdo_sync_q <= {sdo_sync_q[0], bus.sdo_pad};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  // Bus conditions seen from the second flop onward
  assign scl_s = scl_sync_q[1];
  assign sda_s = sda_sync_q[1];
  assign i2c_mode = cs_sync_q[1];
  assign scl_rise = scl_s && !scl_prev_q;
  assign scl_fall = !scl_s && scl_prev_q;
  assign start_det = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  assign stop_det = scl_s && scl_prev_q && !sda_prev_q && sda_s;

  // ----------------------------------------------------------------------
  // Mode and busy status
  // ----------------------------------------------------------------------
  logic bus_busy_q;
  logic spi_select_q;
  logic spi_three_wire_q;

  // Busy from START to STOP; SPI selection from the CS strap
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_busy_q <= 1'b0;
      spi_select_q <= 1'b0;
      spi_three_wire_q <= 1'b0;
    end else begin
      if (!i2c_mode || stop_det) begin
        bus_busy_q <= 1'b0;
      end else if (start_det) begin
        bus_busy_q <= 1'b1;
      end
      spi_select_q <= !i2c_mode;
      spi_three_wire_q <= !i2c_mode && three_wire_select;
    end
  end

  // ----------------------------------------------------------------------
  // Two-entry write buffer toward the register file
  // ----------------------------------------------------------------------
  logic head_v_q;
  logic tail_v_q;
  logic [FW-1:0] head_q;
  logic [FW-1:0] tail_q;
  logic [FW-1:0] push_data;
  logic push;
  logic pop;
  logic fifo_in_ready;
  acc_tgt_state_t state_q;
  acc_byte_kind_t kind_q;
  acc_byte_t shift_q;
  acc_reg_addr_t ptr_q;
  logic [3:0] bit_q;

  assign fifo_in_ready = !tail_v_q;
  assign pop = head_v_q && wr_ready;
  assign push_data = {ptr_q, shift_q};
  assign push = fifo_in_ready && kind_q == K_DATA &&
    ((state_q == T_RX && scl_fall && bit_q == `ACC_BITS_PER_BYTE) || state_q == T_HOLD);

  // Head feeds the user side; tail absorbs one byte while head stalls
  always_ff @(posedge clk) begin
    if (rst) begin
      head_v_q <= 1'b0;
      tail_v_q <= 1'b0;
      head_q <= '0;
      tail_q <= '0;
    end else if (pop) begin
      if (tail_v_q) begin
        head_q <= tail_q;
        tail_v_q <= push;
        tail_q <= push_data;
      end else begin
        head_v_q <= push;
        head_q <= push_data;
      end
    end else if (push) begin
      if (!head_v_q) begin
        head_v_q <= 1'b1;
        head_q <= push_data;
      end else begin
        tail_v_q <= 1'b1;
        tail_q <= push_data;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------------
  logic read_q;
  logic inc_q;
  logic mack_q;
  logic sda_oe_q;
  logic scl_oe_q;

  // Byte framing, acknowledge, pointer and data shifting
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= T_IDLE;
      kind_q <= K_ADDR;
      shift_q <= '0;
      ptr_q <= '0;
      bit_q <= '0;
      read_q <= 1'b0;
      inc_q <= 1'b0;
      mack_q <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else if (!i2c_mode || stop_det) begin
      state_q <= T_IDLE;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else if (start_det) begin
      state_q <= T_RX;
      kind_q <= K_ADDR;
      bit_q <= '0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else begin
      unique case (state_q)
        T_IDLE, T_SKIP: begin
          sda_oe_q <= 1'b0;
        end
        T_RX: begin
          if (scl_rise && bit_q != `ACC_BITS_PER_BYTE) begin
            shift_q <= {shift_q[6:0], sda_s};
            bit_q <= bit_q + 4'd1;
          end else if (scl_fall && bit_q == `ACC_BITS_PER_BYTE) begin
            bit_q <= '0;
            unique case (kind_q)
              K_ADDR: begin
                if (shift_q[7:1] == {`ACC_ADDR_HI, sdo_sync_q[1]} && !target_busy) begin
                  read_q <= shift_q[0];
                  sda_oe_q <= 1'b1;
                  state_q <= T_ACK;
                end else begin
                  state_q <= T_SKIP;
                end
              end
              K_PTR: begin
                ptr_q <= shift_q[6:0];
                inc_q <= shift_q[`ACC_AUTOINC_BIT];
                sda_oe_q <= 1'b1;
                state_q <= T_ACK;
              end
              default: begin
                if (fifo_in_ready) begin
                  sda_oe_q <= 1'b1;
                  ptr_q <= inc_q ? ptr_q + 7'h01 : ptr_q;
                  state_q <= T_ACK;
                end else begin
                  scl_oe_q <= 1'b1;
                  state_q <= T_HOLD;
                end
              end
            endcase
          end
        end
        T_HOLD: begin
          if (fifo_in_ready) begin
            sda_oe_q <= 1'b1;
            ptr_q <= inc_q ? ptr_q + 7'h01 : ptr_q;
            state_q <= T_ACK;
          end
        end
        T_ACK: begin
          scl_oe_q <= 1'b0; // Stretch ends after ack is set up
          if (scl_fall) begin
            if (kind_q == K_ADDR && read_q == `ACC_DIR_READ) begin
              shift_q <= rd_data;
              sda_oe_q <= !rd_data[7];
              ptr_q <= inc_q ? ptr_q + 7'h01 : ptr_q;
              state_q <= T_TX;
            end else begin
              sda_oe_q <= 1'b0;
              kind_q <= (kind_q == K_ADDR) ? K_PTR : K_DATA;
              state_q <= T_RX;
            end
          end
        end
        T_TX: begin
          if (scl_fall) begin
            if (bit_q == `ACC_LAST_BIT) begin
              bit_q <= '0;
              sda_oe_q <= 1'b0;
              state_q <= T_MACK;
            end else begin
              shift_q <= {shift_q[6:0], 1'b0};
              sda_oe_q <= !shift_q[6];
              bit_q <= bit_q + 4'd1;
            end
          end
        end
        T_MACK: begin
          if (scl_rise) begin
            mack_q <= !sda_s;
          end else if (scl_fall) begin
            if (mack_q) begin
              shift_q <= rd_data;
              sda_oe_q <= !rd_data[7];
              ptr_q <= inc_q ? ptr_q + 7'h01 : ptr_q;
              state_q <= T_TX;
            end else begin
              state_q <= T_SKIP;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign bus.tgt_scl_o = 1'b0;
  assign bus.tgt_scl_oe = scl_oe_q;
  assign bus.tgt_sda_o = 1'b0;
  assign bus.tgt_sda_oe = sda_oe_q;
  assign rd_addr = ptr_q;
  assign wr_valid = head_v_q;
  assign wr_addr = head_q[FW-1 -: 7];
  assign wr_data = head_q[7:0];
  assign bus_busy = bus_busy_q;
  assign spi_select = spi_select_q;
  assign spi_three_wire = spi_three_wire_q;
endmodule : acc_i2c_target

// ### acc_consts.svh
// Constants for the accelerometer I2C register-access link
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH
// ----------------------------------------------------------------------
// Addressing
// ----------------------------------------------------------------------
`define ACC_ADDR_HI 6'h0e
`define ACC_DIR_WRITE 1'b0
`define ACC_DIR_READ 1'b1
`define ACC_AUTOINC_BIT 7
`define ACC_BITS_PER_BYTE 4'd8
`define ACC_LAST_BIT 4'd7
// ----------------------------------------------------------------------
// Timing: fast-mode bus rate and half SCL period in clk cycles
// ----------------------------------------------------------------------
`define ACC_CLK_NS 5
`define ACC_SCL_KHZ 400
`define ACC_SCL_PERIOD_NS (1000000 / `ACC_SCL_KHZ)
`define ACC_HALF_CYC ((`ACC_SCL_PERIOD_NS + 2 * `ACC_CLK_NS - 1) / (2 * `ACC_CLK_NS))
`endif

// ### acc_pkg.sv
// Types shared by both ends of the accelerometer I2C link
package acc_pkg;
  typedef logic [7:0] acc_byte_t;
  typedef logic [6:0] acc_reg_addr_t;
  typedef enum logic [2:0] {T_IDLE, T_RX, T_HOLD, T_ACK, T_TX, T_MACK, T_SKIP} acc_tgt_state_t;
  typedef enum logic [1:0] {K_ADDR, K_PTR, K_DATA} acc_byte_kind_t;
  typedef enum logic [2:0] {
    H_IDLE, H_START, H_BIT, H_RS_LOW, H_RS_HIGH, H_STOP_LOW, H_STOP_HIGH, H_STOP_FREE
  } acc_host_state_t;
  typedef enum logic [2:0] {S_ADDR_W, S_PTR, S_WDATA, S_ADDR_R, S_RDATA} acc_host_stage_t;
endpackage : acc_pkg

// ### acc_i2c_if.sv
// Open-drain I2C wires plus mode strap pins between controller and target
`timescale 1ns/1ps
interface acc_i2c_if;
  logic ctl_scl_o;
  logic ctl_scl_oe;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  logic tgt_scl_o;
  logic tgt_scl_oe;
  logic tgt_sda_o;
  logic tgt_sda_oe;
  logic cs;
  logic sdo_pad;
  logic scl;
  logic sda;
  // Wired-AND with pull-ups: low whenever any enabled driver pulls low
  assign scl = ((ctl_scl_oe && !ctl_scl_o) || (tgt_scl_oe && !tgt_scl_o)) ? 1'b0 : 1'b1;
  assign sda = ((ctl_sda_oe && !ctl_sda_o) || (tgt_sda_oe && !tgt_sda_o)) ? 1'b0 : 1'b1;
  modport target (
    input scl,
    input sda,
    input cs,
    input sdo_pad,
    output tgt_scl_o,
    output tgt_scl_oe,
    output tgt_sda_o,
    output tgt_sda_oe
  );
  modport controller (
    input scl,
    input sda,
    output ctl_scl_o,
    output ctl_scl_oe,
    output ctl_sda_o,
    output ctl_sda_oe,
    output cs
  );
endinterface : acc_i2c_if

// ### acc_i2c_host.sv
// Controller end: drives register write and read transfers on the I2C link
`timescale 1ns/1ps
`include "acc_consts.svh"
module acc_i2c_host #(
  parameter int HALF = `ACC_HALF_CYC,
  parameter logic TGT_LSB = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  acc_i2c_if.controller bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire acc_pkg::acc_byte_t cmd_ptr,
  input wire acc_pkg::acc_byte_t cmd_len,
  input wire acc_pkg::acc_byte_t wdata,
  input wire logic wdata_valid,
  output logic wdata_ready,
  output acc_pkg::acc_byte_t rdata,
  output logic rdata_valid,
  output logic done,
  output logic nacked
);
  import acc_pkg::*;

  localparam logic [15:0] HALF_M1 = 16'(HALF - 1);
  localparam logic [15:0] QTR = 16'(HALF / 2);

  // ----------------------------------------------------------------------
  // Line synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;

  // Two flops before the engine reads the wires
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
    end else begin
      scl_sync_q <= {scl_sync_q[0], bus.scl};
      sda_sync_q <= {sda_sync_q[0], bus.sda};
    end
  end

  // ----------------------------------------------------------------------
  // Half-period divider; stalls while a released SCL is held low
  // ----------------------------------------------------------------------
  acc_host_state_t state_q;
  acc_host_stage_t stage_q;
  logic [15:0] div_q;
  logic scl_oe_q;
  logic sda_oe_q;
  logic need_q;
  logic cnt_en;
  logic tick;
  logic mid;

  assign cnt_en = (scl_oe_q || scl_sync_q[1]) && !(need_q && !wdata_valid);
  assign tick = cnt_en && div_q == HALF_M1;
  assign mid = !scl_oe_q || div_q == QTR;

  // Count of the current half period, held while cnt_en is low
  always_ff @(posedge clk) begin
    if (rst || state_q == H_IDLE) begin
      div_q <= '0;
    end else if (cnt_en) begin
      div_q <= tick ? 16'h0000 : div_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------------
  logic hi_q;
  logic [3:0] bit_q;
  acc_byte_t tx_q;
  acc_byte_t rx_q;
  acc_byte_t left_q;
  acc_byte_t ptr_q;
  logic read_q;
  logic cmd_ready_q;
  logic wdata_ready_q;
  logic rdata_valid_q;
  logic done_q;
  logic nacked_q;
  logic last_rd;

  assign last_rd = left_q == 8'h01;

  // Conditions, bits, acknowledges and byte stages of one transfer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= H_IDLE;
      stage_q <= S_ADDR_W;
      hi_q <= 1'b0;
      bit_q <= '0;
      tx_q <= '0;
      rx_q <= '0;
      left_q <= '0;
      ptr_q <= '0;
      read_q <= 1'b0;
      need_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      cmd_ready_q <= 1'b1;
      wdata_ready_q <= 1'b0;
      rdata_valid_q <= 1'b0;
      done_q <= 1'b0;
      nacked_q <= 1'b0;
    end else begin
      wdata_ready_q <= 1'b0;
      rdata_valid_q <= 1'b0;
      done_q <= 1'b0;
      unique case (state_q)
        H_IDLE: begin
          if (cmd_valid) begin
            cmd_ready_q <= 1'b0;
            read_q <= cmd_read;
            ptr_q <= cmd_ptr;
            left_q <= cmd_len;
            tx_q <= {`ACC_ADDR_HI, TGT_LSB, `ACC_DIR_WRITE};
            stage_q <= S_ADDR_W;
            nacked_q <= 1'b0;
            sda_oe_q <= 1'b1;
            state_q <= H_START;
          end
        end
        H_START: begin
          if (tick) begin
            scl_oe_q <= 1'b1;
            hi_q <= 1'b0;
            bit_q <= '0;
            state_q <= H_BIT;
          end
        end
        H_BIT: begin
          if (!hi_q && need_q && wdata_valid && mid) begin
            tx_q <= wdata;
            need_q <= 1'b0;
            wdata_ready_q <= 1'b1;
            sda_oe_q <= !wdata[7];
          end else if (!hi_q && div_q == QTR && !need_q) begin
            if (bit_q == `ACC_BITS_PER_BYTE) begin
              sda_oe_q <= stage_q == S_RDATA && !last_rd;
            end else begin
              sda_oe_q <= stage_q != S_RDATA && !tx_q[7];
            end
          end
          if (tick && !hi_q) begin
            scl_oe_q <= 1'b0;
            hi_q <= 1'b1;
          end else if (tick) begin
            scl_oe_q <= 1'b1;
            hi_q <= 1'b0;
            if (bit_q != `ACC_BITS_PER_BYTE) begin
              rx_q <= {rx_q[6:0], sda_sync_q[1]};
              tx_q <= {tx_q[6:0], 1'b0};
              bit_q <= bit_q + 4'd1;
            end else begin
              bit_q <= '0;
              if (stage_q == S_RDATA) begin
                rdata_valid_q <= 1'b1;
                left_q <= left_q - 8'h01;
                state_q <= last_rd ? H_STOP_LOW : H_BIT;
              end else if (sda_sync_q[1]) begin
                nacked_q <= 1'b1;
                state_q <= H_STOP_LOW;
              end else begin
                unique case (stage_q)
                  S_ADDR_W: begin
                    tx_q <= ptr_q;
                    stage_q <= S_PTR;
                  end
                  S_PTR: begin
                    if (read_q) begin
                      tx_q <= {`ACC_ADDR_HI, TGT_LSB, `ACC_DIR_READ};
                      stage_q <= S_ADDR_R;
                      state_q <= H_RS_LOW;
                    end else begin
                      need_q <= 1'b1;
                      stage_q <= S_WDATA;
                    end
                  end
                  S_WDATA: begin
                    left_q <= left_q - 8'h01;
                    need_q <= !last_rd;
                    state_q <= last_rd ? H_STOP_LOW : H_BIT;
                  end
                  default: begin
                    stage_q <= S_RDATA;
                  end
                endcase
              end
            end
          end
        end
        H_RS_LOW: begin
          sda_oe_q <= div_q < QTR ? sda_oe_q : 1'b0;
          if (tick) begin
            scl_oe_q <= 1'b0;
            state_q <= H_RS_HIGH;
          end
        end
        H_RS_HIGH: begin
          if (tick) begin
            sda_oe_q <= 1'b1;
            state_q <= H_START;
          end
        end
        H_STOP_LOW: begin
          sda_oe_q <= div_q < QTR ? sda_oe_q : 1'b1;
          if (tick) begin
            scl_oe_q <= 1'b0;
            state_q <= H_STOP_HIGH;
          end
        end
        H_STOP_HIGH: begin
          if (tick) begin
            sda_oe_q <= 1'b0;
            state_q <= H_STOP_FREE;
          end
        end
        H_STOP_FREE: begin
          if (tick) begin
            done_q <= 1'b1;
            cmd_ready_q <= 1'b1;
            state_q <= H_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign bus.ctl_scl_o = 1'b0;
  assign bus.ctl_scl_oe = scl_oe_q;
  assign bus.ctl_sda_o = 1'b0;
  assign bus.ctl_sda_oe = sda_oe_q;
  assign bus.cs = 1'b1; // Strap tied high for I2C
  assign cmd_ready = cmd_ready_q;
  assign wdata_ready = wdata_ready_q;
  assign rdata = rx_q;
  assign rdata_valid = rdata_valid_q;
  assign done = done_q;
  assign nacked = nacked_q;
endmodule : acc_i2c_host

// ### acc_i2c_link_props.sv
// Checker watching the I2C wires between controller and target
`timescale 1ns/1ps
module acc_i2c_link_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic ctl_sda_oe,
  input wire logic tgt_scl_oe,
  input wire logic tgt_sda_oe,
  input wire logic sdo_pad,
  input wire logic target_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic scl_q, sda_q, ok_q, rd_q, quiet_q, idle_q;
  logic [3:0] cnt_q;
  logic [7:0] nb_q, sh_q;
  logic rise, start, stop, ack, match;
  // ------------------------------------------------------------------
  // Wire events
  // ------------------------------------------------------------------
  assign rise = scl && !scl_q;
  assign start = scl && scl_q && sda_q && !sda;
  assign stop = scl && scl_q && !sda_q && sda;
  assign ack = rise && cnt_q == 4'h8;
  assign match = sh_q[7:1] == {6'h0e, sdo_pad};
  // Previous wire levels
  always_ff @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
  end
  // Bit and byte position since the last START
  always_ff @(posedge clk) begin
    if (rst || start) begin
      cnt_q <= 4'h0;
      nb_q <= 8'h00;
    end else if (rise) begin
      cnt_q <= ack ? 4'h0 : cnt_q + 4'h1;
      nb_q <= ack ? nb_q + 8'h01 : nb_q;
      sh_q <= ack ? sh_q : {sh_q[6:0], sda};
    end
  end
  // Addressing outcome and spans where the target keeps off the wires
  always_ff @(posedge clk) begin
    if (rst) begin
      ok_q <= 1'b0;
      rd_q <= 1'b0;
      quiet_q <= 1'b0;
      idle_q <= 1'b1;
    end else if (start) begin
      quiet_q <= 1'b0;
      idle_q <= 1'b0;
    end else if (stop) begin
      idle_q <= 1'b1;
    end else if (ack && nb_q == 8'h00) begin
      ok_q <= match && !target_busy;
      rd_q <= sh_q[0];
      quiet_q <= !(match && !target_busy);
    end else if (ack && rd_q && ok_q && sda) begin
      quiet_q <= 1'b1;
    end
  end
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  a_foreign_addr_nack: assert property (ack && nb_q == 8'h00 && !match |-> sda)
    else $error("foreign address acknowledged");
  a_busy_addr_nack: assert property (ack && nb_q == 8'h00 && target_busy |-> sda)
    else $error("busy target acknowledged");
  a_own_addr_ack: assert property (ack && nb_q == 8'h00 && match && !target_busy |-> !sda)
    else $error("own address not acknowledged");
  a_write_byte_ack: assert property (ack && nb_q != 8'h00 && ok_q && !rd_q |-> !sda)
    else $error("written byte not acknowledged");
  a_quiet_target: assert property (quiet_q |-> !tgt_sda_oe)
    else $error("target drives while it must be silent");
  a_idle_release: assert property (idle_q |-> !tgt_sda_oe && !tgt_scl_oe)
    else $error("target drives an idle bus");
  a_start_listen: assert property (start |-> !tgt_sda_oe [*8])
    else $error("target drives right after START");
  a_sda_high_hold: assert property (scl && scl_q |-> $stable(tgt_sda_oe))
    else $error("target moved SDA while SCL high");
  a_no_contention: assert property (scl |-> !(ctl_sda_oe && tgt_sda_oe))
    else $error("both ends drive SDA");
  a_stretch_low: assert property ($rose(tgt_scl_oe) |-> !scl_q)
    else $error("stretch began with SCL high");
  // Main scenarios reached
  c_write_ack: cover property (ack && ok_q && !rd_q && !sda);
  c_read_nack: cover property (ack && ok_q && rd_q && nb_q != 8'h00 && sda);
  c_stretch: cover property ($rose(tgt_scl_oe));
endmodule : acc_i2c_link_props

// ### accel_i2c_register_target_tb.sv
// Testbench joining controller and target ends across the I2C wires
`timescale 1ns/1ps
module accel_i2c_register_target_tb;
  import acc_pkg::*;
  localparam int HALF = 16;
  localparam int LIMIT = 60000;
  typedef struct packed {logic rd; acc_byte_t ptr; acc_byte_t len; acc_byte_t base;} acc_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid, cmd_ready, cmd_read, wdata_valid, wdata_ready, rdata_valid, done, nacked;
  logic wr_valid, bus_busy, spi_select, spi_three_wire, three_wire_select, target_busy;
  logic wr_ready = 1'b1;
  logic stretched = 1'b0;
  acc_byte_t cmd_ptr, cmd_len, wdata, rdata, rd_data, wr_data;
  acc_reg_addr_t rd_addr, wr_addr;
  acc_byte_t mem [128];
  acc_byte_t exp_mem [128];
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int stall_end = 0;
  int tn = 0;
  // Plain writes, then reads of the same places
  acc_row_t rows [8] = '{'{1'b0, 8'h20, 8'h01, 8'h5a}, '{1'b0, 8'ha8, 8'h04, 8'h10},
    '{1'b0, 8'h30, 8'h03, 8'hc0}, '{1'b0, 8'hfe, 8'h03, 8'h70}, '{1'b1, 8'h20, 8'h01, 8'h00},
    '{1'b1, 8'ha8, 8'h04, 8'h00}, '{1'b1, 8'h30, 8'h02, 8'h00}, '{1'b1, 8'hfe, 8'h03, 8'h00}};
  acc_i2c_if bus_if ();
  acc_i2c_host #(.HALF(HALF), .TGT_LSB(1'b1)) acc_i2c_host_inst (.clk(clk), .rst(rst),
    .bus(bus_if.controller), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
    .cmd_ptr(cmd_ptr), .cmd_len(cmd_len), .wdata(wdata), .wdata_valid(wdata_valid),
    .wdata_ready(wdata_ready), .rdata(rdata), .rdata_valid(rdata_valid), .done(done),
    .nacked(nacked));
  acc_i2c_target acc_i2c_target_inst (.clk(clk), .rst(rst), .bus(bus_if.target),
    .three_wire_select(three_wire_select), .target_busy(target_busy), .rd_addr(rd_addr),
    .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
    .wr_data(wr_data), .bus_busy(bus_busy), .spi_select(spi_select),
    .spi_three_wire(spi_three_wire));
  acc_i2c_link_props acc_i2c_link_props_inst (.clk(clk), .rst(rst), .scl(bus_if.scl),
    .sda(bus_if.sda), .ctl_sda_oe(bus_if.ctl_sda_oe), .tgt_scl_oe(bus_if.tgt_scl_oe),
    .tgt_sda_oe(bus_if.tgt_sda_oe), .sdo_pad(bus_if.sdo_pad), .target_busy(target_busy));
  // Register file behind the target, read combinationally
  assign rd_data = mem[rd_addr];
  initial forever #2.5 clk = ~clk;
  // Cycle count, timeout, stretch watch and register writes
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (bus_if.tgt_scl_oe === 1'b1) stretched <= 1'b1;
    if (!rst && wr_valid && wr_ready) mem[wr_addr] <= wr_data;
    if (cyc == LIMIT) begin
      n_errors++;
      results();
    end
  end
  // Sink stalls until the set cycle
  always @(negedge clk) wr_ready <= cyc >= stall_end;
  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  function automatic int reg_at(acc_byte_t p, int k);
    return (p[6:0] + (p[7] ? k : 0)) % 128;
  endfunction : reg_at
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic results();
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  task automatic run(input acc_row_t r, input logic nak);
    int k;
    int got;
    k = 0;
    got = 0;
    check(8'(bus_busy), 8'h00);
    for (int i = 0; i < r.len; i++) if (!r.rd && !nak) exp_mem[reg_at(r.ptr, i)] = r.base + 8'(i);
    @(negedge clk);
    {cmd_valid, cmd_read, cmd_ptr, cmd_len, wdata, wdata_valid} = {1'b1, r, 1'b1};
    @(negedge clk);
    cmd_valid = 1'b0;
    do begin
      @(negedge clk);
      if (wdata_ready === 1'b1 || rdata_valid === 1'b1) check(8'(bus_busy), 8'h01);
      if (wdata_ready === 1'b1) begin
        k++;
        wdata = r.base + 8'(k);
      end
      if (rdata_valid === 1'b1) begin
        check(rdata, exp_mem[reg_at(r.ptr, got)]);
        got++;
      end
    end while (done !== 1'b1);
    check(8'(nacked), 8'(nak));
    if (r.rd && !nak) check(8'(got), r.len);
    tn++;
    $display("test %0d done", tn);
  endtask : run
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    {cmd_valid, cmd_read, cmd_ptr, cmd_len, wdata, wdata_valid} = '0;
    three_wire_select = 1'b1;
    target_busy = 1'b0;
    bus_if.sdo_pad = 1'b1;
    for (int i = 0; i < 128; i++) {mem[i], exp_mem[i]} = {2{8'(i * 3)}};
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    @(negedge clk);
    check({6'h00, cmd_ready, wr_valid}, 8'h02);
    check({1'b0, rd_addr}, 8'h00);
    check({6'h00, spi_select, spi_three_wire}, 8'h00);
    $display("test reset done");
    foreach (rows[i]) run(rows[i], 1'b0);
    stall_end = cyc + 2000;
    run('{1'b0, 8'h85, 8'h05, 8'he0}, 1'b0);
    check(8'(stretched), 8'h01);
    run('{1'b1, 8'h85, 8'h05, 8'h00}, 1'b0);
    bus_if.sdo_pad = 1'b0;
    run('{1'b0, 8'h40, 8'h01, 8'h99}, 1'b1);
    bus_if.sdo_pad = 1'b1;
    target_busy = 1'b1;
    run('{1'b1, 8'h40, 8'h01, 8'h00}, 1'b1);
    target_busy = 1'b0;
    for (int i = 0; i < 128; i++) check(mem[i], exp_mem[i]);
    results();
  end
endmodule : accel_i2c_register_target_tb
